/* bcc_pkg.sv */
package bcc_pkg;

	// Parity space select field encodings
	localparam logic [1:0] PSEL_OFF       = 2'h0;
	localparam logic [1:0] PSEL_DRAM      = 2'h1;
	localparam logic [1:0] PSEL_DRAM_AREA2 = 2'h2;

	// Fixed state counts of bus cycles, boot mode value and area codes
	localparam logic [2:0] ST_ONE    = 3'h1;
	localparam logic [2:0] ST_TWO    = 3'h2;
	localparam logic [2:0] ST_THREE  = 3'h3;
	localparam logic [2:0] ST_FOUR   = 3'h4;
	localparam logic [2:0] BOOT_ROM  = 3'h2;
	localparam logic [2:0] AREA_ROM  = 3'h0;
	localparam logic [2:0] AREA_DRAM = 3'h1;
	localparam logic [2:0] AREA_PAR2 = 3'h2;
	localparam logic [2:0] AREA_PERI = 3'h5;
	localparam logic [2:0] AREA_MIO  = 3'h6;
	localparam logic [2:0] AREA_RAM  = 3'h7;

	// Reset values
	localparam logic [3:0] CNT_RST  = 4'h0;
	localparam logic [1:0] LW_RST   = 2'h0;

	typedef enum logic [3:0] {
		ARB_IDLE = 4'b0001,
		ARB_CYC  = 4'b0010,
		ARB_REL  = 4'b0100,
		ARB_RFSH = 4'b1000
	} bcc_arb_e;

	typedef enum logic [1:0] {
		OWN_CPU = 2'b01,
		OWN_DMA = 2'b10
	} bcc_own_e;

	// One bus cycle request from the internal side
	typedef struct packed {
		logic       valid;
		logic       write;
		logic       dma_single;
		logic [2:0] area;
		logic       a27;
		logic       dram;
		logic       mio;
		logic       a0;
		logic       hi_byte;
		logic       lo_byte;
	} bcc_req_s;

	// Configuration bits
	typedef struct packed {
		logic [1:0] parity_space_sel;
		logic       parity_polarity;
		logic       parity_force;
		logic       byte_access_select;
		logic       warp;
		logic [7:0] wait_ctrl_1;
		logic [7:0] wait_ctrl_2;
		logic       write_wait_bit;
		logic [1:0] long_wait;
		logic [2:0] boot_mode_pins;
	} bcc_cfg_s;

	// External strobes
	typedef struct packed {
		logic write_high_n;
		logic write_low_n;
		logic write_n;
		logic high_byte_strobe_n;
		logic low_byte_strobe_n;
		logic addr0;
	} bcc_strb_s;

endpackage

/* bcc_top.sv */
`timescale 1ns/1ps
module bcc_top
	import bcc_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire bcc_cfg_s    cfg,
	input  wire bcc_req_s    cpu_req,
	input  wire bcc_req_s    dma_req,
	input  wire logic        int_req,
	input  wire logic        refresh_req,
	input  wire logic        bus_request_n,
	input  wire logic        wait_n,
	input  wire logic [15:0] addr_data_bus_in,
	input  wire logic        parity_pin_upper_in,
	input  wire logic        parity_pin_lower_in,
	input  wire logic        parity_err_clr,
	output logic             bus_ack_n,
	output logic             cpu_done,
	output logic             dma_done,
	output logic             int_go,
	output logic             refresh_go,
	output bcc_strb_s        strobes,
	output logic             parity_pin_upper_out,
	output logic             parity_pin_lower_out,
	output logic             parity_pin_oe,
	output logic             parity_error_irq,
	output logic [15:0]      read_data
);

	typedef struct packed {
		bcc_arb_e   arb;
		bcc_own_e   own;
		bcc_req_s   cur;
		logic [3:0] cnt;
		logic       wait_ok;
		logic       first;
		logic       ack_n;
		logic       cpu_done;
		logic       dma_done;
		logic       int_go;
		logic       rf_go;
		bcc_strb_s  strb;
		logic       dp_hi;
		logic       dp_lo;
		logic       dp_oe;
		logic       perr;
		logic [15:0] rdata;
	} bcc_state_s;

	bcc_state_s state_reg;
	bcc_state_s state_next;

	// Even count of ones in a byte gives zero; polarity 1 asks for odd total
	function automatic logic byte_parity(input logic [7:0] d, input logic odd);
		byte_parity = (^d) ^ odd;
	endfunction

	// Is the access in the selected parity space
	function automatic logic in_parity_space(input bcc_req_s r, input logic [1:0] sel);
		logic dram_hit;
		logic a2_hit;
		dram_hit = r.dram && (r.area == AREA_DRAM);
		a2_hit = !r.dram && (r.area == AREA_PAR2);
		in_parity_space = ((sel == PSEL_DRAM) && dram_hit) ||
			((sel == PSEL_DRAM_AREA2) && (dram_hit || a2_hit));
	endfunction

	// Fixed part of the cycle length and whether the wait pin is honoured
	function automatic logic [3:0] cycle_states(input bcc_req_s r, input bcc_cfg_s c,
		output logic wsample);
		logic bit_on;
		logic [3:0] n;
		bit_on = c.wait_ctrl_1[r.area] | c.wait_ctrl_2[r.area];
		wsample = 1'b0;
		n = {1'b0, ST_ONE};
		if (r.area == AREA_ROM && c.boot_mode_pins == BOOT_ROM) begin
			n = {1'b0, ST_ONE};
		end else if (r.area == AREA_RAM && !r.a27) begin
			n = {1'b0, ST_ONE};
		end else if (r.area == AREA_PERI && r.a27) begin
			n = {1'b0, ST_THREE};
		end else if (r.mio && r.area == AREA_MIO) begin
			n = {1'b0, ST_FOUR};
			wsample = 1'b1;
		end else if (r.dram && r.area == AREA_DRAM) begin
			// Write column length follows the write wait bit
			if (r.write ? c.write_wait_bit : bit_on) begin
				n = {1'b0, ST_TWO};
				wsample = 1'b1;
			end
		end else if (r.area == AREA_ROM || r.area == AREA_PAR2 || r.area == AREA_MIO) begin
			// Long wait field 0..3 encodes 2..5 states
			n = 4'({1'b0, ST_ONE}) + 4'(c.long_wait) + 4'h1;
			wsample = r.write | bit_on;
		end else if (r.write || bit_on) begin
			n = {1'b0, ST_TWO};
			wsample = 1'b1;
		end else begin
			n = {1'b0, ST_ONE};
		end
		cycle_states = n;
	endfunction

	// Next state logic
	always_comb begin
		logic ws;
		logic [3:0] n;
		logic par;
		bcc_req_s pick;
		ws = 1'b0;
		n = CNT_RST;
		par = 1'b0;
		pick = '0;
		state_next = state_reg;
		state_next.cpu_done = 1'b0;
		state_next.dma_done = 1'b0;
		state_next.int_go = 1'b0;
		state_next.rf_go = 1'b0;
		// Clear loses to a new error in the same cycle
		if (parity_err_clr) begin
			state_next.perr = 1'b0;
		end
		unique case (state_reg.arb)
			ARB_IDLE: begin
				state_next.strb = '1;
				state_next.strb.addr0 = 1'b0;
				state_next.dp_oe = 1'b0;
				if (!bus_request_n) begin
					state_next.arb = ARB_REL;
					state_next.ack_n = refresh_req;
				end else if (refresh_req) begin
					state_next.arb = ARB_RFSH;
				end else if (dma_req.valid || cpu_req.valid) begin
					pick = dma_req.valid ? dma_req : cpu_req;
					state_next.own = dma_req.valid ? OWN_DMA : OWN_CPU;
					state_next.cur = pick;
					n = cycle_states(pick, cfg, ws);
					state_next.cnt = n;
					state_next.wait_ok = ws;
					state_next.first = 1'b1;
					state_next.arb = ARB_CYC;
					if (pick.write) begin
						// Scheme select: split write strobes or common write with byte strobes
						if (cfg.byte_access_select) begin
							state_next.strb.write_n = 1'b0;
							state_next.strb.high_byte_strobe_n = !pick.hi_byte;
							state_next.strb.low_byte_strobe_n = !pick.lo_byte;
						end else begin
							state_next.strb.write_high_n = !pick.hi_byte;
							state_next.strb.write_low_n = !pick.lo_byte;
							state_next.strb.addr0 = pick.a0;
						end
					end else begin
						// Reads mark their byte lanes, so the far side knows a cycle is on
						state_next.strb.high_byte_strobe_n = !pick.hi_byte;
						state_next.strb.low_byte_strobe_n = !pick.lo_byte;
					end
					if (pick.write && in_parity_space(pick, cfg.parity_space_sel)) begin
						state_next.dp_oe = 1'b1;
						state_next.dp_hi = cfg.parity_force ? 1'b1 :
							byte_parity(addr_data_bus_in[15:8], cfg.parity_polarity);
						state_next.dp_lo = cfg.parity_force ? 1'b1 :
							byte_parity(addr_data_bus_in[7:0], cfg.parity_polarity);
					end
				end
			end
			ARB_CYC: begin
				state_next.first = 1'b0;
				// Warp: internal access joins a write cycle from its second state
				if (cfg.warp && state_reg.cur.write && !state_reg.first && int_req) begin
					state_next.int_go = 1'b1;
				end
				// Wait pin stretches only at the last state of the cycle
				if (state_reg.cnt > 4'h1) begin
					state_next.cnt = state_reg.cnt - 4'h1;
				end else if (state_reg.wait_ok && !wait_n) begin
					state_next.cnt = 4'h1;
				end else begin
					// Cycle ends; a pending external request is honoured after it
					state_next.arb = ARB_IDLE;
					state_next.cnt = CNT_RST;
					state_next.strb = '1;
					state_next.strb.addr0 = 1'b0;
					state_next.dp_oe = 1'b0;
					state_next.cpu_done = (state_reg.own == OWN_CPU);
					state_next.dma_done = (state_reg.own == OWN_DMA);
					if (!state_reg.cur.write) begin
						state_next.rdata = addr_data_bus_in;
						if (in_parity_space(state_reg.cur, cfg.parity_space_sel)) begin
							par = (byte_parity(addr_data_bus_in[15:8], cfg.parity_polarity)
								!= parity_pin_upper_in) ||
								(byte_parity(addr_data_bus_in[7:0], cfg.parity_polarity)
								!= parity_pin_lower_in);
							if (par) begin
								state_next.perr = 1'b1;
							end
						end
					end
				end
			end
			ARB_REL: begin
				// Refresh pending: signal it by raising acknowledge, keep bus out
				if (refresh_req) begin
					state_next.ack_n = 1'b1;
				end else begin
					state_next.ack_n = 1'b0;
				end
				if (bus_request_n) begin
					state_next.ack_n = 1'b1;
					state_next.arb = refresh_req ? ARB_RFSH : ARB_IDLE;
				end
			end
			ARB_RFSH: begin
				state_next.rf_go = 1'b1;
				state_next.arb = ARB_IDLE;
			end
			default: begin
				state_next.arb = ARB_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= '0;
			state_reg.arb <= ARB_IDLE;
			state_reg.own <= OWN_CPU;
			state_reg.ack_n <= 1'b1;
			state_reg.strb <= 6'h3e;
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs straight from state
	assign bus_ack_n = state_reg.ack_n;
	assign cpu_done = state_reg.cpu_done;
	assign dma_done = state_reg.dma_done;
	assign int_go = state_reg.int_go;
	assign refresh_go = state_reg.rf_go;
	assign strobes = state_reg.strb;
	assign parity_pin_upper_out = state_reg.dp_hi;
	assign parity_pin_lower_out = state_reg.dp_lo;
	assign parity_pin_oe = state_reg.dp_oe;
	assign parity_error_irq = state_reg.perr;
	assign read_data = state_reg.rdata;

endmodule

/* bcc_monitor.sv */
`timescale 1ns/1ps
module bcc_monitor
	import bcc_pkg::*;
(
	input wire logic	mclk,
	input wire logic	rstn,
	input wire bcc_cfg_s	cfg,
	input wire logic	bus_request_n,
	input wire logic	refresh_req,
	input wire logic	parity_err_clr,
	input wire logic	bus_ack_n,
	input wire logic	cpu_done,
	input wire logic	dma_done,
	input wire logic	refresh_go,
	input wire logic	parity_pin_upper_out,
	input wire logic	parity_pin_lower_out,
	input wire logic	parity_pin_oe,
	input wire logic	parity_error_irq
);
	// One domain, so clock and reset are given once
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	// Parity pins drive only into a selected space, forced high under test
	property p_force; parity_pin_oe && cfg.parity_force |-> parity_pin_upper_out && parity_pin_lower_out; endproperty
	a_force: assert property (p_force) else $error("force");
	property p_space; parity_pin_oe |-> cfg.parity_space_sel != PSEL_OFF; endproperty
	a_space: assert property (p_space) else $error("space");
	// Release follows a request, never in the cycle that completes
	property p_rel; $fell(bus_ack_n) |-> !$past(bus_request_n) && !cpu_done && !dma_done; endproperty
	a_rel: assert property (p_rel) else $error("release");
	property p_quiet; !bus_ack_n |-> !cpu_done && !dma_done && !refresh_go; endproperty
	a_quiet: assert property (p_quiet) else $error("quiet");
	// Refresh raises the acknowledge and runs only with the bus back
	property p_refr; !bus_ack_n && refresh_req |=> bus_ack_n; endproperty
	a_refr: assert property (p_refr) else $error("refresh ack");
	property p_rgo; refresh_go |-> bus_ack_n && $past(bus_ack_n); endproperty
	a_rgo: assert property (p_rgo) else $error("refresh go");
	// Error flag is sticky until a clear in a quiet cycle
	property p_hold; parity_error_irq && !parity_err_clr |=> parity_error_irq; endproperty
	a_hold: assert property (p_hold) else $error("irq hold");
	property p_clr; parity_error_irq && parity_err_clr && !cpu_done && !dma_done |=> !parity_error_irq; endproperty
	a_clr: assert property (p_clr) else $error("irq clear");

	// Main scenarios reached
	c_rel: cover property ($fell(bus_ack_n));
	c_irq: cover property ($rose(parity_error_irq));
	c_rfsh: cover property (refresh_go);
endmodule

bind bcc_top bcc_monitor u_mon (.*);

/* bcc_ext_model.sv */
`timescale 1ns/1ps
module bcc_ext_model
	import bcc_pkg::*;
(
	input wire logic	mclk,
	input wire logic	rstn,
	input wire bcc_strb_s	strobes,
	input wire logic	bus_ack_n,
	input wire logic [15:0]	word,
	input wire logic	pol,
	input wire logic	bad,
	input wire logic	want,
	input wire logic [3:0]	stall,
	output logic	wait_n,
	output logic [15:0]	addr_data_bus_in,
	output logic	parity_pin_upper_in,
	output logic	parity_pin_lower_in,
	output logic	bus_request_n
);
	logic [3:0]	idx;
	logic	held;
	logic [5:0]	wt;
	logic	sel;

	// Any low strobe means a cycle is on the pins
	assign sel = ~&{strobes.write_high_n, strobes.write_low_n, strobes.write_n,
		strobes.high_byte_strobe_n, strobes.low_byte_strobe_n};
	// Stall the first cycles of each access
	assign wait_n = !(sel && idx < stall);
	// Idle bus shows the inverse, so stale data never looks good
	assign addr_data_bus_in = sel ? word : ~word;
	assign parity_pin_upper_in = ^word[15:8] ^ pol ^ bad ^ !sel;
	assign parity_pin_lower_in = ^word[7:0] ^ pol ^ !sel;

	// Master gives the bus back on a raised acknowledge, and withdraws its request if no grant comes within 40 cycles
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			idx <= 4'h0;
			held <= 1'b0;
			wt <= 6'h00;
			bus_request_n <= 1'b1;
		end else begin
			idx <= sel ? idx + 4'h1 : 4'h0;
			held <= want && (held || !bus_ack_n);
			wt <= (!want || held) ? 6'h00 : wt + {5'h00, wt != 6'h28};
			bus_request_n <= !want || (held ? bus_ack_n : wt == 6'h28);
		end
	end
endmodule

/* testbench.sv */
`timescale 1ns/1ps
module testbench
	import bcc_pkg::*;
;
	logic	mclk = 1'b0;
	logic	rstn = 1'b0;
	bcc_cfg_s	cfg;
	bcc_req_s	cpu_req, dma_req;
	bcc_strb_s	strobes;
	logic [15:0]	word, read_data, addr_data_bus_in;
	logic [3:0]	stall;
	logic	int_req, refresh_req, parity_err_clr, want, bad, wait_n, bus_request_n;
	logic	parity_pin_upper_in, parity_pin_lower_in, bus_ack_n, cpu_done, dma_done, int_go;
	logic	refresh_go, parity_pin_upper_out, parity_pin_lower_out, parity_pin_oe, parity_error_irq;
	logic	wd, so, su, sl;
	int	bad_count = 0;
	int	checked = 0;
	int	n, ig;

	bcc_top uut (.*);
	bcc_ext_model xm (.*, .pol(cfg.parity_polarity));

	// 20 MHz clock
	always #25 mclk = ~mclk;

	task chk(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask

	task close_out;
		if (bad_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	function bcc_req_s mk(input logic [2:0] a, input logic w, input logic d, input logic m, input logic h);
		mk = '{valid: 1'b1, write: w, area: a, a27: h, dram: d, mio: m, hi_byte: 1'b1, lo_byte: 1'b1, default: 1'b0};
	endfunction

	// Hold request until done; count edges from the drive edge, snapshot parity pins
	task run(input bcc_req_s r, input logic [1:0] who);
		@(posedge mclk);
		if (who[0]) cpu_req <= r;
		if (who[1]) dma_req <= r;
		n = 0;
		ig = 0;
		so = 1'b0;
		repeat (40) begin
			@(posedge mclk) #1;
			n++;
			ig += int_go;
			if (parity_pin_oe) {so, su, sl} = {1'b1, parity_pin_upper_out, parity_pin_lower_out};
			wd = dma_done;
			if (cpu_done | dma_done) break;
		end
		if (cpu_done) cpu_req.valid <= 1'b0;
		if (dma_done) dma_req.valid <= 1'b0;
	endtask

	// Done is seen N plus waits edges after the take, one more counted from the drive edge
	task tc(input bcc_req_s r, input logic wb, input logic [3:0] st, input int e);
		cfg.wait_ctrl_1 <= wb ? 8'h01 << r.area : 8'h00;
		stall <= st;
		run(r, 2'b01);
		chk(16'(n), 16'(e + 1));
	endtask

	// Hang guard, far beyond the whole sequence
	initial begin
		repeat (20000) @(posedge mclk);
		bad_count++;
		close_out;
	end

	initial begin
		cfg = '{boot_mode_pins: BOOT_ROM, default: '0};
		cpu_req = '0;
		dma_req = '0;
		{int_req, refresh_req, parity_err_clr, want, bad, stall} = '0;
		word = 16'h0107;
		repeat (20) @(posedge mclk);
		rstn <= 1'b1;
		tc(mk(3, 0, 0, 0, 0), 0, 3, 1);
		tc(mk(3, 0, 0, 0, 0), 1, 2, 3);
		for (int i = 0; i < 4; i++) begin
			cfg.long_wait <= 2'(i);
			tc(mk(2, 0, 0, 0, 0), 0, 3, 2 + i);
		end
		cfg.long_wait <= LW_RST;
		tc(mk(1, 0, 1, 0, 0), 0, 3, 1);
		tc(mk(1, 0, 1, 0, 0), 1, 2, 3);
		tc(mk(4, 1, 0, 0, 0), 0, 1, 2);
		cfg.write_wait_bit <= 1'b1;
		tc(mk(1, 1, 1, 0, 0), 0, 1, 2);
		tc(mk(6, 0, 0, 1, 0), 0, 4, 5);
		tc(mk(5, 0, 0, 0, 1), 1, 3, 3);
		tc(mk(7, 0, 0, 0, 0), 1, 3, 1);
		tc(mk(0, 0, 0, 0, 0), 1, 3, 1);
		// Parity space, sense, force, error flag
		cfg.parity_space_sel <= PSEL_DRAM;
		cfg.parity_polarity <= 1'b1;
		tc(mk(2, 1, 0, 0, 0), 0, 0, 2);
		chk(16'(so), 16'h0000);
		cfg.parity_space_sel <= PSEL_DRAM_AREA2;
		tc(mk(2, 1, 0, 0, 0), 0, 0, 2);
		chk(16'({so, su, sl}), 16'({1'b1, ~^word[15:8], ~^word[7:0]}));
		cfg.parity_force <= 1'b1;
		tc(mk(2, 1, 0, 0, 0), 0, 0, 2);
		chk(16'({so, su, sl}), 16'h0007);
		cfg.parity_force <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			cfg.parity_polarity <= 1'(i);
			tc(mk(2, 0, 0, 0, 0), 0, 0, 2);
			chk(16'(parity_error_irq), 16'h0000);
		end
		chk(read_data, word);
		bad <= 1'b1;
		tc(mk(1, 0, 1, 0, 0), 0, 0, 1);
		chk(16'(parity_error_irq), 16'h0001);
		@(posedge mclk) parity_err_clr <= 1'b1;
		@(posedge mclk) parity_err_clr <= 1'b0;
		@(posedge mclk) #1;
		chk(16'(parity_error_irq), 16'h0000);
		cfg.parity_space_sel <= PSEL_OFF;
		tc(mk(1, 0, 1, 0, 0), 0, 0, 1);
		chk(16'(parity_error_irq), 16'h0000);
		bad <= 1'b0;
		// Both masters at once, then warp overlap
		run(mk(3, 0, 0, 0, 0), 2'b11);
		chk(16'(wd), 16'h0001);
		run(cpu_req, 2'b00);
		chk(16'(cpu_done), 16'h0001);
		cfg.warp <= 1'b1;
		int_req <= 1'b1;
		tc(mk(3, 1, 0, 0, 0), 0, 0, 2);
		chk(16'(ig), 16'h0001);
		int_req <= 1'b0;
		// Release, refresh while released, then resume
		@(posedge mclk) want <= 1'b1;
		for (int k = 0; k < 20 && bus_ack_n; k++) @(posedge mclk) #1;
		chk(16'(bus_ack_n), 16'h0000);
		@(posedge mclk) cpu_req <= mk(3, 0, 0, 0, 0);
		@(posedge mclk) refresh_req <= 1'b1;
		for (int k = 0; k < 30 && !refresh_go; k++) @(posedge mclk) #1;
		chk(16'(refresh_go), 16'h0001);
		@(posedge mclk) refresh_req <= 1'b0;
		want <= 1'b0;
		run(cpu_req, 2'b00);
		chk(16'(cpu_done), 16'h0001);
		close_out;
	end
endmodule
